// ---- ppoc_pkg.sv ----
// Package of constants and types for the port pin override control block
package ppoc_pkg;

   // ==========================================================
   // Port geometry
   localparam int PIN_COUNT = 8;
   localparam int ADDR_W    = 4;
   localparam int DATA_W    = 8;

   // ==========================================================
   // Register offsets (word index on the plain register port)
   localparam logic [3:0] OFS_PIN_SAMPLE = 4'h0;
   localparam logic [3:0] OFS_DIRECTION  = 4'h1;
   localparam logic [3:0] OFS_OUT_LATCH  = 4'h2;
   localparam logic [3:0] OFS_MCU_CTRL   = 4'h3;
   localparam logic [3:0] OFS_IRQ_ENABLE = 4'h4;
   localparam logic [3:0] OFS_IRQ_MODE   = 4'h5;
   localparam logic [3:0] OFS_IRQ_STATUS = 4'h6;
   localparam logic [3:0] OFS_IRQ_MASK   = 4'h7;

   // ==========================================================
   // Field positions and reset values
   localparam int          BIT_PUD       = 0;
   localparam logic [7:0]  RST_BYTE      = 8'h00;
   localparam logic [7:0]  ZERO_BYTE     = 8'h00;
   localparam logic [2:0]  PU_ON_CODE    = 3'h2;

   // Sleep controller states of the surrounding chip
   typedef enum logic [2:0] {
      SLP_ACTIVE   = 3'b000,
      SLP_IDLE     = 3'b001,
      SLP_ADC_NR   = 3'b010,
      SLP_PWR_DOWN = 3'b011,
      SLP_PWR_SAVE = 3'b100,
      SLP_STANDBY  = 3'b101
   } ppoc_sleep_t;

endpackage

// ---- ppoc_ovr_if.sv ----
// Interface carrying per-pin override signals from alternate functions
`timescale 1ns/100ps
interface ppoc_ovr_if;
   logic [7:0] pullupOverrideEn;
   logic [7:0] pullupOverrideVal;
   logic [7:0] dirOverrideEn;
   logic [7:0] dirOverrideVal;
   logic [7:0] outvalOverrideEn;
   logic [7:0] outvalOverrideVal;
   logic [7:0] toggleOverrideEn;
   logic [7:0] inputEnOverrideEn;
   logic [7:0] inputEnOverrideVal;

   // Top side drives the overrides
   modport src (
      output pullupOverrideEn, pullupOverrideVal, dirOverrideEn,
      output dirOverrideVal, outvalOverrideEn, outvalOverrideVal,
      output toggleOverrideEn, inputEnOverrideEn, inputEnOverrideVal
   );
   // Pin logic reads them
   modport sink (
      input pullupOverrideEn, pullupOverrideVal, dirOverrideEn,
      input dirOverrideVal, outvalOverrideEn, outvalOverrideVal,
      input toggleOverrideEn, inputEnOverrideEn, inputEnOverrideVal
   );
endinterface

// ---- ppoc_pin_mux.sv ----
// Combinational per-pin override merge for one port
`timescale 1ns/100ps
module ppoc_pin_mux (
   // Register bits
   input  wire logic [7:0] directionBit,
   input  wire logic [7:0] outputLatchBit,
   input  wire logic       pullupGlobalDisable,
   input  wire logic       inReset,
   // Sleep gating per pin before overrides
   input  wire logic [7:0] sleepGate,
   // Alternate function overrides
   ppoc_ovr_if.sink        ovr,
   // Pad controls
   output logic [7:0]      padOe,
   output logic [7:0]      padOut,
   output logic [7:0]      pullupEn,
   output logic [7:0]      inputEn
);

   // ==========================================================
   // Per-pin merge
   genvar g;
   generate
      for (g = 0; g < ppoc_pkg::PIN_COUNT; g++) begin : gPin
         logic puDefault;
         // Pull-up on for direction/latch/disable = 010
         assign puDefault = ({directionBit[g], outputLatchBit[g],
                              pullupGlobalDisable}
                             == ppoc_pkg::PU_ON_CODE);
         // Pull-up override, killed during reset
         assign pullupEn[g] = !inReset &&
            (ovr.pullupOverrideEn[g] ? ovr.pullupOverrideVal[g]
                                     : puDefault);
         // Driver enable
         assign padOe[g] = ovr.dirOverrideEn[g] ? ovr.dirOverrideVal[g]
                                                : directionBit[g];
         // Driven value, zero when driver is off
         assign padOut[g] = padOe[g] &&
            (ovr.outvalOverrideEn[g] ? ovr.outvalOverrideVal[g]
                                     : outputLatchBit[g]);
         // Digital input enable
         assign inputEn[g] = ovr.inputEnOverrideEn[g]
                             ? ovr.inputEnOverrideVal[g]
                             : !sleepGate[g];
      end
   endgenerate

endmodule

// ---- ppoc_port.sv ----
// Port pin override control: one 8-pin port with registers and interrupts
//
// Operation
// - Deep sleep states assert shared sleep gating, clamping inputs low.
// - Pins with enabled external interrupt escape sleep gating.
// - Disabled edge-interrupt pin high at sleep sets its flag on wake.
// - All pull-ups are off while reset is active.
// - Pull-up override selects value; else pull-up when bits are 010.
// - Direction override selects driver enable; else the direction bit.
// - Driven value is override value when enabled, else latch bit.
// - Toggle override inverts the output latch bit.
// - Input enable override beats sleep state.
// - Raw post-Schmitt input goes to alternate functions unsynchronised.
// - Analog pad link bypasses all digital gating.
// - Port strobes shared by pins; clock, sleep, disable shared by ports; here each port holds its own pullupGlobalDisable bit at OFS_MCU_CTRL.
// - Without overrides, direction picks output or input, with pull-up if the latch bit is 1.
// - Global pull-up disable kills pull-ups on every pin without pull-up override.
// - Pin level is latched on high clock, then registered.
// - Writing one to pin-sample bit toggles the latch bit.
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module ppoc_port (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Register port
   input  wire logic [3:0] regAddr,
   input  wire logic [7:0] regWdata,
   input  wire logic       regWrite,
   input  wire logic       regRead,
   output logic [7:0]      regRdata,
   // Sleep controller state
   input  wire logic [2:0] sleepState,
   // Alternate function overrides
   input  wire logic [7:0] pullup_override_en,
   input  wire logic [7:0] pullup_override_val,
   input  wire logic [7:0] dir_override_en,
   input  wire logic [7:0] dir_override_val,
   input  wire logic [7:0] outval_override_en,
   input  wire logic [7:0] outval_override_val,
   input  wire logic [7:0] toggle_override_en,
   input  wire logic [7:0] input_en_override_en,
   input  wire logic [7:0] input_en_override_val,
   output logic [7:0]      alt_raw_digital_in,
   // Pads
   input  wire logic [7:0] padIn,
   output logic [7:0]      padOut,
   output logic [7:0]      padOe,
   output logic [7:0]      pullupEn,
   output logic [7:0]      inputEn,
   // Analog pad link passes level straight through
   input  wire logic [7:0] alt_analog_pad_link_in,
   output logic [7:0]      alt_analog_pad_link,
   // Interrupt
   output logic            irq
);

   // ==========================================================
   // State
   typedef struct packed {
      logic [7:0] direction;
      logic [7:0] outLatch;
      logic       pullupGlobalDisable;
      logic [7:0] irqEnable;
      logic [7:0] irqEdgeMode;
      logic [7:0] irqStatus;
      logic [7:0] irqMask;
      logic [7:0] pinSample;
      logic [7:0] prevSample;
      logic [7:0] sleepHigh;
      logic       wasSleep;
      logic       rstDone;
      logic [7:0] rdata;
   } ppoc_state_t;

   ppoc_state_t stQ;
   ppoc_state_t stD;

   logic       deepSleep;
   logic [7:0] sleepGate;
   logic [7:0] schmittOut;
   logic [7:0] edgeEvent;
   logic [7:0] wakeEvent;
   logic [7:0] ioSel;
   logic [7:0] syncLatch;

   ppoc_ovr_if ovr ();

   // ==========================================================
   // Decode helper
   function automatic logic hit(input logic [3:0] a,
                                input logic [3:0] ofs);
      hit = (a == ofs);
   endfunction

   // Overrides from peripherals; unconnected ones are tied low outside
   assign ovr.pullupOverrideEn   = pullup_override_en;
   assign ovr.pullupOverrideVal  = pullup_override_val;
   assign ovr.dirOverrideEn      = dir_override_en;
   assign ovr.dirOverrideVal     = dir_override_val;
   assign ovr.outvalOverrideEn   = outval_override_en;
   assign ovr.outvalOverrideVal  = outval_override_val;
   assign ovr.toggleOverrideEn   = toggle_override_en;
   assign ovr.inputEnOverrideEn  = input_en_override_en;
   assign ovr.inputEnOverrideVal = input_en_override_val;

   // ==========================================================
   // Sleep gating
   assign deepSleep = (sleepState == ppoc_pkg::SLP_PWR_DOWN) ||
                      (sleepState == ppoc_pkg::SLP_PWR_SAVE) ||
                      (sleepState == ppoc_pkg::SLP_STANDBY);
   // Enabled interrupt pins stay awake
   assign sleepGate  = {8{deepSleep}} & ~stQ.irqEnable;
   // Clamp to ground ahead of the trigger
   assign schmittOut = padIn & inputEn;
   // Raw input, no synchroniser
   assign alt_raw_digital_in  = schmittOut;
   // Analog path bypasses gating
   assign alt_analog_pad_link = alt_analog_pad_link_in;

   // ==========================================================
   // Pin merge
   ppoc_pin_mux uMux (
      .directionBit        (stQ.direction),
      .outputLatchBit      (stQ.outLatch),
      .pullupGlobalDisable (stQ.pullupGlobalDisable),
      .inReset             (!stQ.rstDone),
      .sleepGate           (sleepGate),
      .ovr                 (ovr),
      .padOe               (padOe),
      .padOut              (padOut),
      .pullupEn            (pullupEn),
      .inputEn             (inputEn)
   );

   // Edge events and wake events
   assign edgeEvent = (stQ.pinSample ^ stQ.prevSample) & stQ.irqEnable &
                      stQ.irqEdgeMode;
   assign wakeEvent = (stQ.wasSleep && !deepSleep) ?
                      (stQ.sleepHigh & ~stQ.irqEnable & stQ.irqEdgeMode)
                      : ppoc_pkg::ZERO_BYTE;
   assign ioSel     = {8{regWrite}};

   // ==========================================================
   // Next state
   always_comb begin
      stD = stQ;
      stD.rstDone    = 1'b1;
      stD.prevSample = stQ.pinSample;
      stD.pinSample  = syncLatch;
      stD.wasSleep   = deepSleep;
      // Capture levels on entering deep sleep
      if (deepSleep && !stQ.wasSleep) begin
         stD.sleepHigh = stQ.pinSample;
      end
      // Register writes, shared strobes for all pins
      if (regWrite) begin
         if (hit(regAddr, ppoc_pkg::OFS_DIRECTION)) begin
            stD.direction = regWdata;
         end
         if (hit(regAddr, ppoc_pkg::OFS_OUT_LATCH)) begin
            stD.outLatch = regWdata;
         end
         if (hit(regAddr, ppoc_pkg::OFS_PIN_SAMPLE)) begin
            stD.outLatch = stQ.outLatch ^ (regWdata & ioSel);
         end
         if (hit(regAddr, ppoc_pkg::OFS_MCU_CTRL)) begin
            stD.pullupGlobalDisable = regWdata[ppoc_pkg::BIT_PUD];
         end
         if (hit(regAddr, ppoc_pkg::OFS_IRQ_ENABLE)) begin
            stD.irqEnable = regWdata;
         end
         if (hit(regAddr, ppoc_pkg::OFS_IRQ_MODE)) begin
            stD.irqEdgeMode = regWdata;
         end
         if (hit(regAddr, ppoc_pkg::OFS_IRQ_STATUS)) begin
            stD.irqStatus = stQ.irqStatus & ~regWdata;
         end
         if (hit(regAddr, ppoc_pkg::OFS_IRQ_MASK)) begin
            stD.irqMask = regWdata;
         end
      end
      // Toggle override inverts latch, on top of any write
      stD.outLatch = stD.outLatch ^ ovr.toggleOverrideEn;
      // Events win over a clear in the same cycle
      stD.irqStatus = stD.irqStatus | edgeEvent | wakeEvent;
      // Read data, valid the cycle after the strobe
      stD.rdata = ppoc_pkg::ZERO_BYTE;
      if (regRead) begin
         unique case (regAddr)
            ppoc_pkg::OFS_PIN_SAMPLE: stD.rdata = stQ.pinSample;
            ppoc_pkg::OFS_DIRECTION:  stD.rdata = stQ.direction;
            ppoc_pkg::OFS_OUT_LATCH:  stD.rdata = stQ.outLatch;
            ppoc_pkg::OFS_MCU_CTRL:
               stD.rdata = {7'h00, stQ.pullupGlobalDisable};
            ppoc_pkg::OFS_IRQ_ENABLE: stD.rdata = stQ.irqEnable;
            ppoc_pkg::OFS_IRQ_MODE:   stD.rdata = stQ.irqEdgeMode;
            ppoc_pkg::OFS_IRQ_STATUS: stD.rdata = stQ.irqStatus;
            ppoc_pkg::OFS_IRQ_MASK:   stD.rdata = stQ.irqMask;
            default:                  stD.rdata = ppoc_pkg::ZERO_BYTE;
         endcase
      end
   end

   // ==========================================================
   // Sync latch, transparent while clock is high; own driver, no race
   always_latch begin
      if (clk) begin
         syncLatch <= schmittOut;
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stQ <= '0;
      end else begin
         stQ <= stD;
      end
   end

   // Outputs
   assign regRdata = stQ.rdata;
   assign irq      = |(stQ.irqStatus & stQ.irqMask);

endmodule

// ---- ppoc_port_monitor.sv ----
// Checker of pad control relations of the port
`timescale 1ns/100ps
module ppoc_port_monitor (
   // Clock, reset and sleep state
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic [2:0] sleepState,
   // Overrides
   input wire logic [7:0] pullup_override_en,
   input wire logic [7:0] pullup_override_val,
   input wire logic [7:0] dir_override_en,
   input wire logic [7:0] dir_override_val,
   input wire logic [7:0] outval_override_en,
   input wire logic [7:0] outval_override_val,
   input wire logic [7:0] input_en_override_en,
   input wire logic [7:0] input_en_override_val,
   input wire logic [7:0] alt_raw_digital_in,
   // Pads
   input wire logic [7:0] padIn,
   input wire logic [7:0] padOut,
   input wire logic [7:0] padOe,
   input wire logic [7:0] pullupEn,
   input wire logic [7:0] inputEn,
   input wire logic [7:0] alt_analog_pad_link_in,
   input wire logic [7:0] alt_analog_pad_link
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ======================================
   // Pad control relations
   AST_PU_OVR: assert property (
      ((pullupEn ^ pullup_override_val) & pullup_override_en) == 8'h00)
      else $error("pull-up ignores its override");
   AST_PU_DIR: assert property (
      (pullupEn & padOe & ~pullup_override_en & ~dir_override_en) == 8'h00)
      else $error("pull-up on a driven pin");
   AST_DIR_OVR: assert property (
      ((padOe ^ dir_override_val) & dir_override_en) == 8'h00)
      else $error("driver enable ignores its override");
   AST_OUT_OVR: assert property (
      ((padOut ^ outval_override_val) & padOe & outval_override_en) == 8'h00)
      else $error("driven value ignores its override");
   AST_IE_OVR: assert property (
      ((inputEn ^ input_en_override_val) & input_en_override_en) == 8'h00)
      else $error("input enable ignores its override");
   AST_IE_AWAKE: assert property (
      sleepState < 3'h3 |-> (inputEn | input_en_override_en) == 8'hff)
      else $error("input gated while awake");
   AST_RAW_IN: assert property (
      alt_raw_digital_in == (padIn & inputEn))
      else $error("raw input differs from gated pad");
   AST_ANALOG: assert property (
      alt_analog_pad_link == alt_analog_pad_link_in)
      else $error("analog link not straight through");
   AST_RST_PU: assert property (
      $rose(rst_n) |-> pullupEn == 8'h00)
      else $error("pull-up on right after reset");
endmodule

// ---- ppoc_pad_model.sv ----
// Board model of the pads: drivers, pull-ups and outside sources
`timescale 1ns/100ps
module ppoc_pad_model (
   // Clock for the floating pattern
   input  wire logic       clk,
   // Device pad controls
   input  wire logic [7:0] padOe,
   input  wire logic [7:0] padOut,
   input  wire logic [7:0] pullupEn,
   // Outside source commanded by the bench
   input  wire logic [7:0] extEn,
   input  wire logic [7:0] extVal,
   // Pad level
   output logic [7:0]      padLevel
);
   logic [7:0] floatQ = 8'h55;
   // Undriven pads wander every cycle
   always_ff @(posedge clk) floatQ <= ~floatQ;
   // Device driver wins, then outside source, then pull-up
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (padOe[i]) padLevel[i] = padOut[i];
         else if (extEn[i]) padLevel[i] = extVal[i];
         else if (pullupEn[i]) padLevel[i] = 1'b1;
         else padLevel[i] = floatQ[i];
      end
   end
endmodule

// ---- tb_ppoc_port.sv ----
// Self-checking bench of the port pin override control block
`timescale 1ns/100ps
module tb_ppoc_port;
   logic       clk, rst_n, regWrite, regRead, irq;
   logic [3:0] regAddr;
   logic [2:0] sleepState;
   logic [7:0] regWdata, regRdata, v, puEn, puVal, ddEn, ddVal;
   logic [7:0] pvEn, pvVal, tgEn, ieEn, ieVal, rawIn, padIn, padOut;
   logic [7:0] padOe, pullupEn, inputEn, anaOut, extEn, extVal;
   int         failures, totalChecks, cyc;
   ppoc_port dut_u (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
      .regRdata(regRdata), .sleepState(sleepState),
      .pullup_override_en(puEn), .pullup_override_val(puVal),
      .dir_override_en(ddEn), .dir_override_val(ddVal),
      .outval_override_en(pvEn), .outval_override_val(pvVal),
      .toggle_override_en(tgEn), .input_en_override_en(ieEn),
      .input_en_override_val(ieVal), .alt_raw_digital_in(rawIn),
      .padIn(padIn), .padOut(padOut), .padOe(padOe), .pullupEn(pullupEn),
      .inputEn(inputEn), .alt_analog_pad_link_in(padIn),
      .alt_analog_pad_link(anaOut), .irq(irq));
   ppoc_pad_model pad_u (.clk(clk), .padOe(padOe), .padOut(padOut),
      .pullupEn(pullupEn), .extEn(extEn), .extVal(extVal),
      .padLevel(padIn));
   // Clock and hang guard
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         wrap_up();
      end
   end
   // ======================================
   // Shared tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      totalChecks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 v = regRdata;
   endtask
   task automatic wrap_up;
      $display("checks=%0d failures=%0d", totalChecks, failures);
      if (failures == 0 && totalChecks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ======================================
   // Scenarios
   task automatic t_gpio;
      wr(4'h1, 8'h0f);
      wr(4'h2, 8'h33);
      chk(padOe, 8'h0f);
      chk(padOut & 8'h0f, 8'h03);
      chk(pullupEn, 8'h30);
      rd(4'h1);
      chk(v, 8'h0f);
      wr(4'h3, 8'h01);
      chk(pullupEn, 8'h00);
      rd(4'h3);
      chk(v, 8'h01);
      wr(4'h3, 8'h00);
      rd(4'hf);
      chk(v, 8'h00);
   endtask
   task automatic t_toggle;
      wr(4'h0, 8'h0f);
      rd(4'h2);
      chk(v, 8'h3c);
      @(posedge clk) tgEn <= 8'h10;
      @(posedge clk) tgEn <= 8'h00;
      rd(4'h2);
      chk(v, 8'h2c);
   endtask
   task automatic t_ovr;
      @(posedge clk);
      {puEn, ddEn, pvEn, ieEn} <= {4{8'hff}};
      {puVal, ddVal, pvVal, ieVal} <= 32'h5af0cc3c;
      sleepState <= 3'h3;
      #1 chk(pullupEn, 8'h5a);
      chk(padOe, 8'hf0);
      chk(padOut & 8'hf0, 8'hc0);
      chk(inputEn, 8'h3c);
      @(posedge clk);
      {puEn, ddEn, pvEn, ieEn} <= 32'h0;
      sleepState <= 3'h0;
   endtask
   task automatic t_sample;
      wr(4'h1, 8'h00);
      wr(4'h2, 8'h00);
      @(posedge clk) {extEn, extVal} <= 16'hffa5;
      repeat (3) @(posedge clk);
      rd(4'h0);
      chk(v, 8'ha5);
      chk(rawIn, 8'ha5);
      chk(anaOut, 8'ha5);
   endtask
   task automatic t_sleep;
      wr(4'h4, 8'h01);
      for (int s = 3; s < 6; s++) begin
         @(posedge clk) sleepState <= s[2:0];
         #1 chk(inputEn, 8'h01);
      end
      wr(4'h4, 8'h00);
      chk(inputEn, 8'h00);
      @(posedge clk) sleepState <= 3'h1;
      #1 chk(inputEn, 8'hff);
   endtask
   task automatic t_irq;
      wr(4'h5, 8'h01);
      wr(4'h7, 8'h01);
      wr(4'h6, 8'hff);
      @(posedge clk) sleepState <= 3'h4;
      repeat (3) @(posedge clk);
      sleepState <= 3'h0;
      repeat (3) @(posedge clk);
      rd(4'h6);
      chk(v, 8'h01);
      chk({7'h0, irq}, 8'h01);
      wr(4'h6, 8'h01);
      chk({7'h0, irq}, 8'h00);
      wr(4'h4, 8'h02);
      wr(4'h5, 8'h02);
      wr(4'h7, 8'h00);
      @(posedge clk) extVal <= 8'ha7;
      repeat (3) @(posedge clk);
      rd(4'h6);
      chk(v, 8'h02);
      chk({7'h0, irq}, 8'h00);
      wr(4'h7, 8'h02);
      chk({7'h0, irq}, 8'h01);
      rd(4'h4);
      chk(v, 8'h02);
      rd(4'h5);
      chk(v, 8'h02);
      rd(4'h7);
      chk(v, 8'h02);
   endtask
   task automatic t_reset;
      wr(4'h1, 8'h00);
      wr(4'h2, 8'hff);
      @(posedge clk) extEn <= 8'h00;
      rst_n <= 1'b0;
      {puEn, puVal} <= 16'hffff;
      #1 chk(pullupEn, 8'h00);
      chk(padOe, 8'h00);
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      puEn <= 8'h00;
      rd(4'h2);
      chk(v, 8'h00);
   endtask
   // Main sequence
   initial begin
      {rst_n, regWrite, regRead, regAddr, sleepState} = '0;
      {regWdata, puEn, puVal, ddEn, ddVal, pvEn, pvVal} = '0;
      {tgEn, ieEn, ieVal, extEn, extVal} = '0;
      repeat (10) @(posedge clk);
      chk(pullupEn | padOe, 8'h00);
      rst_n <= 1'b1;
      t_gpio();
      t_toggle();
      t_ovr();
      t_sample();
      t_sleep();
      t_irq();
      t_reset();
      wrap_up();
   end
endmodule
bind ppoc_port ppoc_port_monitor mon_u (.clk, .rst_n, .sleepState,
   .pullup_override_en, .pullup_override_val, .dir_override_en,
   .dir_override_val, .outval_override_en, .outval_override_val,
   .input_en_override_en, .input_en_override_val, .alt_raw_digital_in,
   .padIn, .padOut, .padOe, .pullupEn, .inputEn, .alt_analog_pad_link_in,
   .alt_analog_pad_link);
